/* File: hw/otps_pkg.sv */
// constants shared by the one-time programmable store
//
// Overview of operation
// - A 4096-bit one-time store, read by software after reset.
// - Bits never programmed read back as zero.
// - A bit programmed to one stays one until the next reset.
// - The whole store can be programmed in one write cycle.
// - Separate cycles program chosen bytes; only zero bits may change.
package otps_pkg;
    localparam int OTPS_BITS       = 4096;
    localparam int OTPS_BYTE_W     = 8;
    localparam int OTPS_BYTES      = OTPS_BITS / OTPS_BYTE_W;
    localparam int OTPS_ADDR_W     = $clog2(OTPS_BYTES);
    // programming pulse per byte, in ns, and its cycle count at 25 MHz
    localparam int OTPS_CLK_NS     = 40;
    localparam int OTPS_PROG_NS    = 200;
    localparam int OTPS_PROG_CYC   = (OTPS_PROG_NS + OTPS_CLK_NS - 1)
                                     / OTPS_CLK_NS;
    localparam int OTPS_CNT_W      = 4;
    // reset value of every unprogrammed cell
    localparam logic [7:0] OTPS_BLANK = 8'h00;
    typedef enum logic [2:0] {
        OTPS_IDLE  = 3'b001,
        OTPS_BURN  = 3'b010,
        OTPS_READ  = 3'b100
    } otps_state_t;
endpackage

/* File: hw/otps_cell.sv */
// one byte of fuse storage: bits may only go from zero to one
`timescale 1ns/1ps
`default_nettype none
module otps_cell
    import otps_pkg::*;
#(
    parameter int W = OTPS_BYTE_W
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         burn,
    input  wire logic [W-1:0] burn_data,
    output logic      [W-1:0] value
);
    logic [W-1:0] fuse_r;
    logic [W-1:0] fuse_nxt;

    // or-ing means a one can never be cleared by a later burn
    assign fuse_nxt = burn ? (fuse_r | burn_data) : fuse_r;
    assign value    = fuse_r;

    // reset models a blank part; a real fuse has no reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fuse_r <= W'(OTPS_BLANK);
        end else begin
            fuse_r <= fuse_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: hw/otps_top.sv */
// one-time programmable store: byte read port and byte or bulk programming
`timescale 1ns/1ps
`default_nettype none
module otps_top
    import otps_pkg::*;
#(
    parameter int BYTES = OTPS_BYTES
) (
    // clock and asynchronous active-low reset
    input  wire logic                   clock,
    input  wire logic                   rstn,
    // read port: one byte per request, answered two edges later
    input  wire logic                   rd_req,
    input  wire logic [OTPS_ADDR_W-1:0] rd_addr,
    output logic      [7:0]             rd_data,
    output logic                        rd_valid,
    // programming port: one byte or the whole store per request
    input  wire logic                   wr_req,
    input  wire logic                   wr_all,
    input  wire logic [OTPS_ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]             wr_data,
    output logic                        busy
);
    // elaboration checks: the array, the address port and the burn timer
    // are sized together, so any other combination is refused here
    generate
        if (BYTES != OTPS_BYTES) begin : g_bad_bytes
            $error("store size must match the address port");
        end
        if (OTPS_BYTES != (1 << OTPS_ADDR_W)) begin : g_bad_addr
            $error("address port must cover the store exactly");
        end
        if (OTPS_BYTE_W != $bits(wr_data)) begin : g_bad_byte
            $error("byte ports must match the cell width");
        end
        if (OTPS_BLANK != '0) begin : g_bad_blank
            $error("an unprogrammed cell must read as zero");
        end
        if ((OTPS_BITS % OTPS_BYTE_W) != 0) begin : g_bad_bits
            $error("store size must be a whole number of bytes");
        end
        if (OTPS_PROG_CYC < 1) begin : g_bad_pulse
            $error("burn pulse must last at least one cycle");
        end
        if (OTPS_PROG_CYC > (1 << OTPS_CNT_W)) begin : g_bad_cnt
            $error("burn timer too narrow for the pulse");
        end
    endgenerate

    // control state and the captured request
    otps_state_t                state_r;
    otps_state_t                state_nxt;
    logic [OTPS_CNT_W-1:0]      cnt_r;
    logic [OTPS_CNT_W-1:0]      cnt_nxt;
    logic [OTPS_ADDR_W-1:0]     addr_r;
    logic [OTPS_ADDR_W-1:0]     addr_nxt;
    logic [7:0]                 wdat_r;
    logic [7:0]                 wdat_nxt;
    logic                       all_r;
    logic                       all_nxt;

    // read answer and the byte image of every cell
    logic [7:0]                 rd_data_r;
    logic [7:0]                 rd_data_nxt;
    logic                       rd_valid_r;
    logic                       rd_valid_nxt;
    logic [7:0]                 rd_byte;
    logic [7:0]                 cell_val [BYTES];

    // decode of the state and of the incoming request
    logic                       idle;
    logic                       in_burn;
    logic                       in_read;
    logic                       take_wr;
    logic                       take_rd;
    logic                       take_any;
    logic                       cnt_last;
    logic                       burn_done;

    // state decode; a burn or a read owns the port until it is over
    assign idle      = (state_r == OTPS_IDLE);
    assign in_burn   = (state_r == OTPS_BURN);
    assign in_read   = (state_r == OTPS_READ);

    // request acceptance; a request seen while busy is simply dropped
    assign take_wr   = idle && wr_req;
    assign take_rd   = idle && rd_req && !wr_req; // writes win ties
    assign take_any  = take_wr || take_rd;

    // the pulse ends on the last counted cycle of the burn timer
    assign cnt_last  = (cnt_r == OTPS_CNT_W'(OTPS_PROG_CYC - 1));
    assign burn_done = in_burn && cnt_last;

    // one pulse burns every byte when bulk, else one selected byte
    genvar g;
    generate
        for (g = 0; g < BYTES; g++) begin : g_cell
            wire hit = burn_done &&
                       (all_r || addr_r == OTPS_ADDR_W'(g));
            // each cell comes out of reset blank, as a fresh part would
            otps_cell #(.W(OTPS_BYTE_W)) u_cell (
                .clock     (clock),
                .rstn      (rstn),
                .burn      (hit),
                .burn_data (wdat_r),
                .value     (cell_val[g])
            );
        end
    endgenerate

    // next state: a burn runs its full timer, a read takes one cycle
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            // a write wins over a read raised in the same cycle
            OTPS_IDLE: begin
                if (take_wr) begin
                    state_nxt = OTPS_BURN;
                end else if (take_rd) begin
                    state_nxt = OTPS_READ;
                end
            end
            // cells change on the last timer cycle, then the port frees
            OTPS_BURN: begin
                if (burn_done) begin
                    state_nxt = OTPS_IDLE;
                end
            end
            // the byte is picked here and shown from the next edge on
            OTPS_READ: begin
                state_nxt = OTPS_IDLE;
            end
            // a code with no single hot bit falls back to idle
            default: begin
                state_nxt = OTPS_IDLE;
            end
        endcase
    end

    // timer runs only while burning and restarts from zero for each burn;
    // its width is checked against the pulse length above
    assign cnt_nxt      = in_burn ? cnt_r + 1'b1 : '0;

    // request fields are captured once, when the port takes a request;
    // holding them through the burn keeps a refused write from leaking in
    assign addr_nxt     = take_any ? (take_wr ? wr_addr : rd_addr) : addr_r;
    assign wdat_nxt     = take_any ? wr_data : wdat_r;
    assign all_nxt      = take_any ? (take_wr && wr_all) : all_r;

    // read byte is picked in the read cycle and held until the next read
    assign rd_byte      = cell_val[addr_r];
    assign rd_data_nxt  = in_read ? rd_byte : rd_data_r;
    assign rd_valid_nxt = in_read;

    // control state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= OTPS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // burn timer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // captured byte address
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            addr_r <= '0;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    // captured ones to burn
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wdat_r <= OTPS_BLANK;
        end else begin
            wdat_r <= wdat_nxt;
        end
    end

    // captured bulk flag
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            all_r <= 1'b0;
        end else begin
            all_r <= all_nxt;
        end
    end

    // read byte from a flop, so software sees it steady between reads
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data_r <= OTPS_BLANK;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // one-cycle mark that a fresh read byte stands on the port
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // outputs; busy is decoded from the state flop, so it rises on the edge that takes a request
    assign rd_data  = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign busy     = !idle;
endmodule
`default_nettype wire

/* File: bench/otps_sva.sv */
// port timing checker for the one-time programmable store
`timescale 1ns/1ps
`default_nettype none
module otps_sva (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       rd_req,
    input wire logic       wr_req,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic       busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // a taken read answers on the second edge and frees the port
    chk_rd_answer: assert property (!busy && rd_req && !wr_req
        |=> busy ##1 (rd_valid && !busy)) else $error("late read");
    // a burn holds the port for exactly five cycles
    chk_burn_len: assert property (!busy && wr_req
        |=> busy [*5] ##1 !busy) else $error("bad burn length");
    chk_valid_once: assert property (rd_valid |=> !rd_valid)
        else $error("valid too long");
    // read byte only moves with a fresh answer
    chk_data_hold: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data moved");
    chk_idle_stay: assert property (!busy && !rd_req && !wr_req
        |=> !busy) else $error("busy with no request");
    chk_write_quiet: assert property (!busy && wr_req
        |=> !rd_valid [*6]) else $error("read pulse in burn");
endmodule
bind otps_top otps_sva u_otps_sva (.clock(clock), .rstn(rstn),
    .rd_req(rd_req), .wr_req(wr_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy));
`default_nettype wire

/* File: bench/otps_top_tb.sv */
// self-checking bench for the one-time programmable store
`timescale 1ns/1ps
`default_nettype none
module otps_top_tb import otps_pkg::*;;
    logic clock = 0, rstn = 0, rd_req = 0, wr_req = 0, wr_all = 0;
    logic [OTPS_ADDR_W-1:0] rd_addr = 0, wr_addr = 0;
    logic [7:0] wr_data = 0, rd_data;
    logic rd_valid, busy;
    int n_fail = 0, n_tests = 0, cyc = 0;
    // rows: write, bulk, address, data, expected byte; image vetted
    logic [26:0] rows [12] = '{{2'b00, 9'h005, 8'h00, 8'h00},
        {2'b10, 9'h005, 8'h0F, 8'h00}, {2'b00, 9'h005, 8'h00, 8'h0F},
        {2'b10, 9'h005, 8'hF0, 8'h00}, {2'b00, 9'h005, 8'h00, 8'hFF},
        {2'b10, 9'h005, 8'h00, 8'h00}, {2'b00, 9'h005, 8'h00, 8'hFF},
        {2'b00, 9'h1FF, 8'h00, 8'h00}, {2'b11, 9'h000, 8'h81, 8'h00},
        {2'b00, 9'h1FF, 8'h00, 8'h81}, {2'b00, 9'h005, 8'h00, 8'hFF},
        {2'b00, 9'h000, 8'h00, 8'h81}};
    otps_top u_otps_top (.clock(clock), .rstn(rstn), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_req(wr_req), .wr_all(wr_all), .wr_addr(wr_addr),
        .wr_data(wr_data), .busy(busy));
    initial forever #20 clock = ~clock;
    // a hang costs a mismatch rather than a stuck run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 600) begin
            n_fail++;
            test_done();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one request, held for one edge, then wait for the port to free
    task op(input logic [26:0] r);
        @(negedge clock);
        {wr_req, wr_all, wr_addr, wr_data} = r[26:8];
        rd_addr = wr_addr;
        rd_req = !r[26];
        @(negedge clock);
        {rd_req, wr_req, wr_all} = 3'h0;
        for (int k = 0; k < 9 && busy; k++) @(negedge clock);
        if (!r[26]) chk({7'h00, rd_valid}, 8'h01);
        if (!r[26]) chk(rd_data, r[7:0]);
    endtask
    initial begin
        repeat (3) @(negedge clock);
        chk({7'h00, busy}, 8'h00);
        chk(rd_data, 8'h00);
        rstn = 1;
        foreach (rows[i]) op(rows[i]);
        // a second write while busy must be ignored
        @(negedge clock);
        {wr_req, wr_addr, wr_data} = {1'b1, 9'h010, 8'h02};
        @(negedge clock);
        wr_addr = 9'h011;
        @(negedge clock);
        wr_req = 0;
        repeat (5) @(negedge clock);
        op({2'b00, 9'h010, 8'h00, 8'h83});
        op({2'b00, 9'h011, 8'h00, 8'h81});
        // a tie goes to the write; no read answer may follow it
        @(negedge clock);
        {rd_addr, wr_addr, wr_data} = {9'h012, 9'h012, 8'h04};
        {rd_req, wr_req} = 2'b11;
        @(negedge clock);
        {rd_req, wr_req} = 2'b00;
        @(negedge clock);
        chk({7'h00, rd_valid}, 8'h00);
        repeat (5) @(negedge clock);
        op({2'b00, 9'h012, 8'h00, 8'h85});
        rstn = 0;
        @(negedge clock);
        rstn = 1;
        op({2'b00, 9'h005, 8'h00, 8'h00});
        test_done();
    end
endmodule
`default_nettype wire
